// ==== common/mult_map.svh ====
// Register offsets, field positions and reset values of the mixed-mode multiplier
// How it works
// RL1: The X and Y operands each carry their own signed/unsigned select, set independently.
// RL2: A signed operand times an unsigned one yields a two's complement product with no outside help.
// RL3: For a constant multiply the host loads the constant once and then stops loading that operand.
// RL4: In constant multiply each cycle only loads the variable operand and then loads a product word.
// RL5: The bit pattern of the product is the same whether operands are read as integer or fraction.
// RL6: With the result shift on, the upper product word is shifted right one place, halving each bit.
// RL7: With the result shift on, the top bit of the lower word holds the next product bit.
// RL8: With the result shift on, every two's complement product fits, even the most negative squared.
// RL9: The host keeps the result shift on whenever an operand is unsigned.
// RL10: The 24-bit product is presented as a 12-bit upper word and a 12-bit lower word.
// RL11: Each operand and each product word register loads data and format on its own load strobe.
// RL12: The round request is captured whenever either operand is loaded.
// RL13: Each product word drives its pins only while its active-low output enable is low.
// RL14: With the result shift off, the upper word tops with the sign and the lower word repeats it.
`ifndef MULT_MAP_SVH
`define MULT_MAP_SVH
`define REG_X_OPERAND      5'h00
`define REG_Y_OPERAND      5'h04
`define REG_CONTROL        5'h08
`define REG_COMMAND        5'h0C
`define REG_PRODUCT        5'h10
`define OPERAND_SIGNED_BIT 12
`define OPERAND_LSB        0
`define CTL_MSB            3
`define CTL_LSB            0
`define CTL_RESET          4'hC
`define CTL_UPPER_DIS_BIT  2
`define CMD_LOAD_UPPER_BIT 0
`define CMD_LOAD_LOWER_BIT 1
`define PRODUCT_LOWER_LSB  16
`define PRODUCT_UPPER_LSB  0
`define RND_POS_SHIFT      11
`define RND_POS_NORM       10
`define P_SHIFT_MSB        23
`define P_SHIFT_LSB        12
`define P_NORM_MSB         22
`define P_NORM_LSB         11
`define MOST_NEG           12'h800
`define MOST_NEG_SQ_UPPER  12'h400
`endif

// ==== common/mult_pkg.sv ====
// Types shared by the multiplier modules
`default_nettype none
package mult_pkg;
  typedef logic [11:0] word_t;
  typedef struct packed {
    logic  signed_sel;
    word_t data;
  } operand_t;
  typedef struct packed {
    logic lower_word_output_disable;
    logic upper_word_output_disable;
    logic round_request;
    logic result_shift_ctl;
  } ctl_t;
endpackage
`default_nettype wire

// ==== common/mult_if.sv ====
// Operand, format and product signals between register file and multiplier core
`timescale 1ns/10ps
`default_nettype none
interface mult_if;
  import mult_pkg::*;
  word_t x;
  word_t y;
  logic  x_operand_signed_sel;
  logic  y_operand_signed_sel;
  logic  result_shift_ctl;
  logic  round_request;
  word_t upper_product_word;
  word_t lower_product_word;
  modport core (
    input  x, y, x_operand_signed_sel, y_operand_signed_sel, result_shift_ctl, round_request,
    output upper_product_word, lower_product_word
  );
  modport regs (
    output x, y, x_operand_signed_sel, y_operand_signed_sel, result_shift_ctl, round_request,
    input  upper_product_word, lower_product_word
  );
endinterface
`default_nettype wire

// ==== hw/mult_format_core.sv ====
// Mixed-mode 12 x 12 multiplier with rounding and result-shift formatting
`timescale 1ns/10ps
`default_nettype none
`include "mult_map.svh"
module mult_format_core
  import mult_pkg::*;
(
  mult_if.core bus
);
  logic signed [12:0] x_ext;
  logic signed [12:0] y_ext;
  logic signed [25:0] full;
  logic signed [25:0] rnd_add;
  logic signed [25:0] sum;

  // Unsigned operands get a zero guard bit, signed ones a sign copy, so one
  // signed multiplier covers all four format mixes
  always_comb begin
    x_ext = {bus.x_operand_signed_sel & bus.x[11], bus.x}; // RL1
    y_ext = {bus.y_operand_signed_sel & bus.y[11], bus.y}; // RL1
    full = x_ext * y_ext; // RL2 RL5
    rnd_add = '0;
    if (bus.round_request) begin
      rnd_add[bus.result_shift_ctl ? `RND_POS_SHIFT : `RND_POS_NORM] = 1'b1;
    end
    sum = full + rnd_add;
    if (bus.result_shift_ctl) begin
      bus.upper_product_word = sum[`P_SHIFT_MSB:`P_SHIFT_LSB]; // RL6 RL8 RL10
      bus.lower_product_word = sum[`P_SHIFT_LSB-1:0]; // RL7
    end else begin
      bus.upper_product_word = sum[`P_NORM_MSB:`P_NORM_LSB]; // RL14 RL10
      bus.lower_product_word = {sum[`P_NORM_MSB], sum[`P_NORM_LSB-1:0]}; // RL14
    end
  end
endmodule
`default_nettype wire

// ==== hw/mult_shift_top.sv ====
// Avalon-MM register front end and product registers of the mixed-mode multiplier
`timescale 1ns/10ps
`default_nettype none
`include "mult_map.svh"
module mult_shift_top
  import mult_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic [4:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output var  logic [31:0] AVS_READDATA,
  output var  logic        AVS_WAITREQUEST,
  output var  logic [11:0] UPPER_PRODUCT_WORD,
  output var  logic        UPPER_PRODUCT_WORD_EN_N,
  output var  logic [11:0] LOWER_PRODUCT_WORD,
  output var  logic        LOWER_PRODUCT_WORD_EN_N
);
  logic        waitrequest;
  logic [31:0] readdata;
  logic [31:0] next_readdata;
  logic [31:0] merged;
  logic        req;
  logic        wr;
  logic        load_x;
  logic        load_y;
  logic        load_upper;
  logic        load_lower;
  operand_t    x_op;
  operand_t    y_op;
  ctl_t        ctl;
  logic        round_q;
  word_t       upper_q;
  word_t       lower_q;

  mult_if core_bus ();

  // Byte-lane merge of write data into the current register value
  function automatic logic [31:0] merge_lanes(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Transfer qualifiers; a write lands only on the edge where waitrequest is low
  assign req = AVS_READ | AVS_WRITE;
  assign wr  = AVS_WRITE & ~waitrequest;
  assign load_x = wr & (AVS_ADDRESS == `REG_X_OPERAND);
  assign load_y = wr & (AVS_ADDRESS == `REG_Y_OPERAND);
  assign load_upper = wr & (AVS_ADDRESS == `REG_COMMAND) & AVS_BYTEENABLE[0]
                      & AVS_WRITEDATA[`CMD_LOAD_UPPER_BIT];
  assign load_lower = wr & (AVS_ADDRESS == `REG_COMMAND) & AVS_BYTEENABLE[0]
                      & AVS_WRITEDATA[`CMD_LOAD_LOWER_BIT];

  // Old value of the addressed register, used for partial-lane writes
  always_comb begin
    merged = '0;
    unique case (AVS_ADDRESS)
      `REG_X_OPERAND: merged = merge_lanes(32'(x_op), AVS_WRITEDATA, AVS_BYTEENABLE);
      `REG_Y_OPERAND: merged = merge_lanes(32'(y_op), AVS_WRITEDATA, AVS_BYTEENABLE);
      `REG_CONTROL:   merged = merge_lanes(32'(ctl), AVS_WRITEDATA, AVS_BYTEENABLE);
      default:        merged = merge_lanes(32'h0000_0000, AVS_WRITEDATA, AVS_BYTEENABLE);
    endcase
  end

  // One wait state: waitrequest drops for exactly one cycle per request
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= ~(req & waitrequest);
    end
  end

  // Read mux; unmapped offsets and the command register read as zero
  always_comb begin
    next_readdata = '0;
    unique case (AVS_ADDRESS)
      `REG_X_OPERAND: next_readdata = 32'(x_op);
      `REG_Y_OPERAND: next_readdata = 32'(y_op);
      `REG_CONTROL:   next_readdata = 32'(ctl);
      `REG_PRODUCT: begin
        next_readdata[`PRODUCT_LOWER_LSB +: 12] = lower_q;
        next_readdata[`PRODUCT_UPPER_LSB +: 12] = upper_q;
      end
      default:        next_readdata = '0;
    endcase
  end

  // Read data captured as waitrequest falls, so it stands on the completing edge
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      readdata <= '0;
    end else if (AVS_READ & waitrequest) begin
      readdata <= next_readdata;
    end
  end

  // Operand registers carry their format select with the data
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      x_op <= '0;
    end else if (load_x) begin
      x_op <= merged[`OPERAND_SIGNED_BIT:`OPERAND_LSB]; // RL11 RL1
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      y_op <= '0;
    end else if (load_y) begin
      y_op <= merged[`OPERAND_SIGNED_BIT:`OPERAND_LSB]; // RL11 RL1
    end
  end

  // Control: result shift, pending round request and the two output disables
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ctl <= `CTL_RESET;
    end else if (wr & (AVS_ADDRESS == `REG_CONTROL)) begin
      ctl <= merged[`CTL_MSB:`CTL_LSB];
    end
  end

  // Round request follows either operand load, like a clock made of both
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      round_q <= 1'b0;
    end else if (load_x | load_y) begin
      round_q <= ctl.round_request; // RL12
    end
  end

  // Core sees operands and the live shift control; shift is frozen per word at load
  assign core_bus.x = x_op.data;
  assign core_bus.y = y_op.data;
  assign core_bus.x_operand_signed_sel = x_op.signed_sel;
  assign core_bus.y_operand_signed_sel = y_op.signed_sel;
  assign core_bus.result_shift_ctl = ctl.result_shift_ctl;
  assign core_bus.round_request = round_q;

  mult_format_core u_core (
    .bus (core_bus.core)
  );

  // Product word registers, each on its own load strobe
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      upper_q <= '0;
    end else if (load_upper) begin
      upper_q <= core_bus.upper_product_word; // RL11 RL10
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      lower_q <= '0;
    end else if (load_lower) begin
      lower_q <= core_bus.lower_product_word; // RL11 RL10
    end
  end

  // Pins straight from flops; enables are active low and follow the disables
  assign AVS_READDATA = readdata;
  assign AVS_WAITREQUEST = waitrequest;
  assign UPPER_PRODUCT_WORD = upper_q;
  assign LOWER_PRODUCT_WORD = lower_q;
  assign UPPER_PRODUCT_WORD_EN_N = ctl.upper_word_output_disable; // RL13
  assign LOWER_PRODUCT_WORD_EN_N = ctl.lower_word_output_disable; // RL13

  // Reference product for the checks below
  logic signed [25:0] model_full;
  assign model_full = $signed({x_op.signed_sel & x_op.data[11], x_op.data})
                    * $signed({y_op.signed_sel & y_op.data[11], y_op.data});

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  sequence ack_s;
    !waitrequest ##1 waitrequest;
  endsequence

  sequence shift_load_s;
    ctl.result_shift_ctl && !round_q;
  endsequence

  bus_answer_a: assert property (req && waitrequest |=> ack_s)
    else $error("bus answer not one cycle after request");
  x_capture_a: assert property (load_x && (&AVS_BYTEENABLE[1:0]) |=> // RL11
    x_op == $past(AVS_WRITEDATA[`OPERAND_SIGNED_BIT:`OPERAND_LSB]))
    else $error("X operand not captured");
  round_capture_a: assert property (round_q != $past(round_q) |-> // RL12
    $past(load_x | load_y))
    else $error("round changed without operand load");
  upper_hold_a: assert property (!load_upper |=> $stable(upper_q)) // RL11
    else $error("upper word changed without load");
  shift_upper_a: assert property ((load_upper and shift_load_s) |=> // RL6
    upper_q == $past(model_full[`P_SHIFT_MSB:`P_SHIFT_LSB]))
    else $error("shifted upper word wrong");
  shift_lower_a: assert property ((load_lower and shift_load_s) |=> // RL7
    lower_q == $past(model_full[`P_SHIFT_LSB-1:0]))
    else $error("shifted lower word wrong");
  sign_copy_a: assert property (load_lower && !ctl.result_shift_ctl && !round_q |=> // RL14
    lower_q[11] == $past(model_full[`P_NORM_MSB]))
    else $error("lower word top is not the sign");
  neg_square_a: assert property ((load_upper && x_op.signed_sel && y_op.signed_sel // RL8
    && x_op.data == `MOST_NEG && y_op.data == `MOST_NEG) and shift_load_s
    |=> upper_q == `MOST_NEG_SQ_UPPER)
    else $error("most negative square wrong");
  mixed_sign_a: assert property ((load_upper && !x_op.signed_sel && y_op.signed_sel // RL2
    && y_op.data[11] && x_op.data != '0) and shift_load_s |=> upper_q[11])
    else $error("mixed product not negative");
  output_enable_a: assert property (wr && AVS_ADDRESS == `REG_CONTROL && AVS_BYTEENABLE[0] // RL13
    |=> UPPER_PRODUCT_WORD_EN_N == $past(AVS_WRITEDATA[`CTL_UPPER_DIS_BIT]) ##1
    UPPER_PRODUCT_WORD_EN_N == $past(UPPER_PRODUCT_WORD_EN_N) || $past(wr))
    else $error("upper enable does not follow disable bit");
endmodule
`default_nettype wire

// ==== testbench/mult_sink.sv ====
// Far-side reader of the product word pins
`timescale 1ns/10ps
`default_nettype none
module mult_sink
  import mult_pkg::*;
(
  input  wire logic  clk,
  input  wire word_t upper,
  input  wire logic  upper_en_n,
  input  wire word_t lower,
  input  wire logic  lower_en_n,
  output var  word_t upper_seen,
  output var  word_t lower_seen
);
  word_t upper_last;
  word_t lower_last;
  // Last value seen while each word was driven
  always_ff @(posedge clk) begin
    if (!upper_en_n) upper_last <= upper;
    if (!lower_en_n) lower_last <= lower;
  end
  // Released pins float; inverse of old data so stale values never match
  assign upper_seen = upper_en_n ? ~upper_last : upper;
  assign lower_seen = lower_en_n ? ~lower_last : lower;
endmodule
`default_nettype wire

// ==== testbench/tb_mixed_mode_multiplier_shift.sv ====
// Self-checking bench of the mixed-mode multiplier register block
`timescale 1ns/10ps
`default_nettype none
module tb_mixed_mode_multiplier_shift;
  import mult_pkg::*;
  logic        clk;
  logic        rst;
  logic [4:0]  adr;
  logic        rd;
  logic        wr;
  logic [31:0] wdat;
  logic [3:0]  be;
  logic [31:0] rdat;
  logic        wait_req;
  word_t       up_w;
  logic        up_en_n;
  word_t       lo_w;
  logic        lo_en_n;
  word_t       up_seen;
  word_t       lo_seen;
  int          n_errors;
  int          check_count;
  int          cycles;
  mult_shift_top u_dut (
    .CORE_CLK(clk), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wait_req), .UPPER_PRODUCT_WORD(up_w), .UPPER_PRODUCT_WORD_EN_N(up_en_n),
    .LOWER_PRODUCT_WORD(lo_w), .LOWER_PRODUCT_WORD_EN_N(lo_en_n)
  );
  mult_sink u_sink (
    .clk(clk), .upper(up_w), .upper_en_n(up_en_n), .lower(lo_w), .lower_en_n(lo_en_n),
    .upper_seen(up_seen), .lower_seen(lo_seen)
  );
  // Free-running core clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One Avalon cycle; request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] b, output logic [31:0] q);
    @(posedge clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= d;
    be <= b;
    @(posedge clk);
    while (wait_req !== 1'b0) @(posedge clk);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hF, q);
  endtask
  task automatic rd_reg(input logic [4:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0000_0000, 4'hF, q);
  endtask
  // Expected {lower, upper} words from operands and format controls
  function automatic logic [23:0] prod(input word_t x, input logic xs, input word_t y,
                                       input logic ys, input logic rs, input logic rnd);
    logic signed [27:0] p;
    p = $signed({xs & x[11], x}) * $signed({ys & y[11], y});
    if (rnd) p = p + (rs ? 28'sh000_0800 : 28'sh000_0400);
    return rs ? {p[11:0], p[23:12]} : {p[22], p[10:0], p[22:11]};
  endfunction
  // Load operands, load both words, check pins and readback
  task automatic run_mul(input word_t x, input logic xs, input word_t y, input logic ys,
                         input logic rs, input logic rnd, input logic late);
    logic [23:0] e;
    logic [31:0] q;
    e = prod(x, xs, y, ys, rs, rnd);
    wr_reg(5'h08, {30'h0, rnd, rs});
    wr_reg(5'h00, {19'h0, xs, x});
    wr_reg(5'h04, {19'h0, ys, y});
    if (late) wr_reg(5'h08, {30'h0, !rnd, rs});
    wr_reg(5'h0C, 32'h0000_0003);
    @(posedge clk);
    #1;
    check("upper pins", 32'(e[11:0]), 32'(up_seen));
    check("lower pins", 32'(e[23:12]), 32'(lo_seen));
    rd_reg(5'h10, q);
    check("product reg", {4'h0, e[23:12], 4'h0, e[11:0]}, q);
  endtask
  task automatic t_reset();
    logic [31:0] q;
    check("upper en_n", 32'h0000_0001, 32'(up_en_n));
    check("lower en_n", 32'h0000_0001, 32'(lo_en_n));
    rd_reg(5'h08, q);
    check("control", 32'h0000_000C, q);
    wr_reg(5'h14, 32'hFFFF_FFFF);
    rd_reg(5'h14, q);
    check("unmapped", 32'h0000_0000, q);
    bus(1'b1, 5'h08, 32'h0000_0003, 4'h0, q);
    rd_reg(5'h08, q);
    check("masked write", 32'h0000_000C, q);
    rd_reg(5'h10, q);
    check("product reset", 32'h0000_0000, q);
  endtask
  // Every format combination; unsigned and mixed keep the shift on
  task automatic t_modes();
    run_mul(12'h800, 1'b1, 12'h800, 1'b1, 1'b1, 1'b0, 1'b0);
    run_mul(12'h800, 1'b1, 12'h800, 1'b1, 1'b0, 1'b0, 1'b0);
    run_mul(12'h7FF, 1'b1, 12'h801, 1'b1, 1'b0, 1'b0, 1'b0);
    run_mul(12'hFFF, 1'b0, 12'hFFF, 1'b0, 1'b1, 1'b0, 1'b0);
    run_mul(12'hFFF, 1'b0, 12'h800, 1'b1, 1'b1, 1'b0, 1'b0);
    run_mul(12'h800, 1'b1, 12'hFFF, 1'b0, 1'b1, 1'b0, 1'b0);
    run_mul(12'h123, 1'b1, 12'hF00, 1'b1, 1'b1, 1'b0, 1'b0);
  endtask
  // Rounding, including a flag changed after the operands were loaded
  task automatic t_round();
    run_mul(12'h3A7, 1'b1, 12'h5C3, 1'b1, 1'b1, 1'b1, 1'b0);
    run_mul(12'h3A7, 1'b1, 12'h5C3, 1'b1, 1'b0, 1'b1, 1'b1);
    run_mul(12'h3A7, 1'b1, 12'h5C3, 1'b1, 1'b1, 1'b0, 1'b1);
  endtask
  // Constant held in X; last pass loads only the upper word
  task automatic t_const();
    logic [23:0] e;
    logic [23:0] prev;
    word_t       y;
    wr_reg(5'h08, 32'h0000_0001);
    wr_reg(5'h00, 32'h0000_1A05);
    for (int i = 0; i < 4; i++) begin
      prev = e;
      y = 12'(i * 977 + 5);
      e = prod(12'hA05, 1'b1, y, 1'b1, 1'b1, 1'b0);
      wr_reg(5'h04, {19'h0, 1'b1, y});
      wr_reg(5'h0C, (i == 3) ? 32'h0000_0001 : 32'h0000_0003);
      @(posedge clk);
      #1;
      check("const upper", 32'(e[11:0]), 32'(up_seen));
      check("const lower", 32'((i == 3) ? prev[23:12] : e[23:12]), 32'(lo_seen));
    end
  endtask
  // Each word released on its own disable only
  task automatic t_disable();
    logic [23:0] e;
    e = prod(12'h456, 1'b1, 12'h9AB, 1'b1, 1'b1, 1'b0);
    run_mul(12'h456, 1'b1, 12'h9AB, 1'b1, 1'b1, 1'b0, 1'b0);
    wr_reg(5'h08, 32'h0000_0005);
    @(posedge clk);
    #1;
    check("upper off", {20'h0_0000, ~e[11:0]}, 32'(up_seen));
    check("lower on", 32'(e[23:12]), 32'(lo_seen));
    wr_reg(5'h08, 32'h0000_0009);
    @(posedge clk);
    #1;
    check("upper on", 32'(e[11:0]), 32'(up_seen));
    check("lower off", {20'h0_0000, ~e[23:12]}, 32'(lo_seen));
  endtask
  initial begin
    rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    adr = 5'h00;
    wdat = 32'h0000_0000;
    be = 4'h0;
    n_errors = 0;
    check_count = 0;
    cycles = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_modes();
    t_round();
    t_const();
    t_disable();
    end_of_test();
  end
endmodule
`default_nettype wire
